// ===== verilog/mss_pkg.sv
package mss_pkg;
  // Register offsets (word index = byte offset / 4 not used; plain port map)
  localparam logic [3:0] MSS_REG_CTRL = 4'h0;
  localparam logic [3:0] MSS_REG_BST_TIME = 4'h1;
  localparam logic [3:0] MSS_REG_COAST_TIME = 4'h2;
  localparam logic [3:0] MSS_REG_BRAKE_TIME = 4'h3;
  localparam logic [3:0] MSS_REG_PWM_PERIOD = 4'h4;
  localparam logic [3:0] MSS_REG_STAT_THR = 4'h5;
  localparam logic [3:0] MSS_REG_RESYNC_THR = 4'h6;
  localparam logic [3:0] MSS_REG_HANDOFF_THR = 4'h7;
  localparam logic [3:0] MSS_REG_STATUS = 4'h8;
  // Control field positions
  localparam int MSS_CTRL_SPEED_DET_EN = 0;
  localparam int MSS_CTRL_RESYNC_ENABLE = 1;
  localparam int MSS_CTRL_REV_DRV_EN = 2;
  localparam int MSS_CTRL_COAST_EN = 3;
  localparam int MSS_CTRL_BRAKE_EN = 4;
  localparam int MSS_CTRL_DIR_RESTART_MODE = 5;
  localparam int MSS_CTRL_METHOD_LO = 6;
  // Reset values
  localparam logic [7:0] MSS_CTRL_RST = 8'h1f;
  localparam logic [15:0] MSS_TIME_RST = 16'h0064;
  localparam logic [15:0] MSS_PWM_PERIOD_RST = 16'h03e8;
  localparam logic [15:0] MSS_THR_RST = 16'h0010;
  // Low-side on time as a percentage of the PWM period
  localparam int MSS_LS_ON_PCT = 5;
  // Start-up method codes
  localparam logic [1:0] MSS_METHOD_ALIGN = 2'b00;
  localparam logic [1:0] MSS_METHOD_DOUBLE_ALIGN = 2'b01;
  localparam logic [1:0] MSS_METHOD_PROBING = 2'b10;
  localparam logic [1:0] MSS_METHOD_SLOW_CYCLE = 2'b11;
  typedef enum logic [3:0] {
    MSS_POWER_ON, MSS_PRECHARGE, MSS_WAIT_UVLO, MSS_SPEED_DETECT, MSS_COAST, MSS_BRAKE,
    MSS_STARTUP, MSS_OPEN_LOOP, MSS_CLOSED_LOOP, MSS_REV_CLOSED, MSS_REV_OPEN
  } mss_state_t;
endpackage : mss_pkg

// ===== verilog/mss_start_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// R01: precharge pulses low-side gate at PWM rate, 5% on time, high sides off
// R02: precharge each phase in turn for one third of bootstrap charge time
// R03: sequencer enters power-on state at power-up and standby or sleep exit
// R04: direction change with restart mode 0 restarts sequence from any state
// R05: after power-on go to speed detect if enabled, else brake decision
// R06: back-EMF below stationary threshold goes to brake decision, else direction check
// R07: forward spin goes to resync decision, reverse spin to reverse drive decision
// R08: resync enabled compares speed to threshold, else coast decision
// R09: forward speed above resync threshold enters closed loop seeded, else open loop
// R10: reverse spin with reverse drive enabled evaluates reverse speed, else coast decision
// R11: stay in reverse closed-loop decel while speed high, then reverse open loop
// R12: reverse open loop crosses zero, accelerates forward, closed loop when fast enough
// R13: coast decision runs coast when enabled, else brake decision
// R14: coast holds all six gate outputs off for coast duration
// R15: brake decision runs brake when enabled, else motor start-up
// R16: brake turns all three low sides on for brake duration, high sides off
// R17: speed detection waits until bootstrap supply is above undervoltage threshold
// R18: speed detection uses ADC phase voltage results for speed, position, direction
// R19: after the stationary start-up method, move into open-loop acceleration
// R20: method select 00 align, 01 double align, 10 probing, 11 slow cycle
// R21: coast timer expiry continues to brake decision
// R22: brake timer expiry continues to motor start-up state
module mss_start_sequencer #(
  parameter int TW = 16 // Width of time and threshold registers
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  input wire logic wake_event, // Standby or sleep exit, one-cycle pulse
  input wire logic dir_change, // Direction change command, one-cycle pulse
  input wire logic boot_uvlo_ok_pin, // Bootstrap above UVLO, asynchronous pin
  input wire logic detect_done, // ADC speed detection finished, pulse
  input wire logic [TW-1:0] bemf_level, // Measured back-EMF
  input wire logic [TW-1:0] motor_speed, // Measured speed magnitude
  input wire logic spin_reverse, // Detected spin opposite commanded
  input wire logic method_done, // Start-up method finished, pulse
  input wire logic zero_crossed, // Reverse open loop crossed zero speed, level
  output logic detect_start, // Request ADC speed detection, pulse
  output logic seed_closed_loop, // Closed loop seeded by detected speed, pulse
  output logic [1:0] method_run, // Start-up method code being run
  output logic [2:0] gate_high, // High-side gate outputs A,B,C
  output logic [2:0] gate_low, // Low-side gate outputs A,B,C
  output mss_pkg::mss_state_t fsm_state // Current sequencer state
);
  import mss_pkg::*;

  // Registers
  logic [7:0] ctrl_q;
  logic [TW-1:0] bst_time_q, coast_time_q, brake_time_q, pwm_period_q;
  logic [TW-1:0] stat_thr_q, resync_thr_q, handoff_thr_q;
  logic [15:0] rdata_q;
  mss_state_t state_q, state_d;
  logic [TW-1:0] tmr_q, tmr_d, pwm_q;
  logic [1:0] phase_q, phase_d;
  logic uvlo_s1_q, uvlo_s2_q;
  logic [2:0] gl_q, gh_q;
  logic det_start_q, seed_q;
  logic [1:0] method_q;

  // Decoded control bits
  wire speed_detect_enable = ctrl_q[MSS_CTRL_SPEED_DET_EN];
  wire resync_enable = ctrl_q[MSS_CTRL_RESYNC_ENABLE];
  wire reverse_drive_enable = ctrl_q[MSS_CTRL_REV_DRV_EN];
  wire coast_enable = ctrl_q[MSS_CTRL_COAST_EN];
  wire brake_enable = ctrl_q[MSS_CTRL_BRAKE_EN];
  wire dir_restart_mode = ctrl_q[MSS_CTRL_DIR_RESTART_MODE];
  wire [1:0] startup_method_select = ctrl_q[MSS_CTRL_METHOD_LO +: 2];
  wire [TW-1:0] phase_time = TW'(bst_time_q / 3);
  wire [TW-1:0] ls_on_time = TW'((32'(pwm_period_q) * MSS_LS_ON_PCT) / 100);
  wire tmr_done = (tmr_q == '0);
  wire restart = dir_change && !dir_restart_mode;
  // No restart source this cycle
  wire no_restart = !wake_event && !restart;

  // Register write port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= MSS_CTRL_RST;
      bst_time_q <= TW'(MSS_TIME_RST);
      coast_time_q <= TW'(MSS_TIME_RST);
      brake_time_q <= TW'(MSS_TIME_RST);
      pwm_period_q <= TW'(MSS_PWM_PERIOD_RST);
      stat_thr_q <= TW'(MSS_THR_RST);
      resync_thr_q <= TW'(MSS_THR_RST);
      handoff_thr_q <= TW'(MSS_THR_RST);
    end else if (reg_wr) begin
      unique case (reg_addr)
        MSS_REG_CTRL: ctrl_q <= reg_wdata[7:0];
        MSS_REG_BST_TIME: bst_time_q <= TW'(reg_wdata);
        MSS_REG_COAST_TIME: coast_time_q <= TW'(reg_wdata);
        MSS_REG_BRAKE_TIME: brake_time_q <= TW'(reg_wdata);
        MSS_REG_PWM_PERIOD: pwm_period_q <= TW'(reg_wdata);
        MSS_REG_STAT_THR: stat_thr_q <= TW'(reg_wdata);
        MSS_REG_RESYNC_THR: resync_thr_q <= TW'(reg_wdata);
        MSS_REG_HANDOFF_THR: handoff_thr_q <= TW'(reg_wdata);
        default: ;
      endcase
    end
  end

  // Read mux, answered one cycle after the strobe; unmapped reads zero
  wire [15:0] rd_mux =
    (reg_addr == MSS_REG_CTRL) ? {8'h00, ctrl_q} :
    (reg_addr == MSS_REG_BST_TIME) ? 16'(bst_time_q) :
    (reg_addr == MSS_REG_COAST_TIME) ? 16'(coast_time_q) :
    (reg_addr == MSS_REG_BRAKE_TIME) ? 16'(brake_time_q) :
    (reg_addr == MSS_REG_PWM_PERIOD) ? 16'(pwm_period_q) :
    (reg_addr == MSS_REG_STAT_THR) ? 16'(stat_thr_q) :
    (reg_addr == MSS_REG_RESYNC_THR) ? 16'(resync_thr_q) :
    (reg_addr == MSS_REG_HANDOFF_THR) ? 16'(handoff_thr_q) :
    (reg_addr == MSS_REG_STATUS) ? {8'h00, uvlo_s2_q, phase_q, 1'b0, 4'(state_q)} : 16'h0000;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) rdata_q <= 16'h0000;
    else rdata_q <= reg_rd ? rd_mux : 16'h0000;
  end
  assign reg_rdata = rdata_q;

  // Bootstrap UVLO pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      uvlo_s1_q <= 1'b0;
      uvlo_s2_q <= 1'b0;
    end else begin
      uvlo_s1_q <= boot_uvlo_ok_pin;
      // Only the second stage feeds logic; the first may be metastable
      uvlo_s2_q <= uvlo_s1_q;
    end
  end

  // Brake decision: next state from brake enable
  function automatic mss_state_t brake_decide(input logic en);
    // R15: brake or start-up
    brake_decide = en ? MSS_BRAKE : MSS_STARTUP;
  endfunction : brake_decide

  // Coast decision: coast or on to brake decision
  function automatic mss_state_t coast_decide(input logic c_en, input logic b_en);
    // R13: coast or brake decision
    coast_decide = c_en ? MSS_COAST : brake_decide(b_en);
  endfunction : coast_decide

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_done ? '0 : tmr_q - TW'(1);
    phase_d = phase_q;
    unique case (state_q)
      MSS_POWER_ON: begin
        phase_d = 2'd0;
        tmr_d = phase_time;
        state_d = MSS_PRECHARGE;
      end
      MSS_PRECHARGE: begin
        // R02: one third per phase
        if (tmr_done) begin
          if (phase_q == 2'd2) begin
            state_d = MSS_WAIT_UVLO;
          end else begin
            phase_d = phase_q + 2'd1;
            tmr_d = phase_time;
          end
        end
      end
      MSS_WAIT_UVLO: begin
        // R05: detect or skip to brake decision
        if (!speed_detect_enable) begin
          state_d = brake_decide(brake_enable);
          tmr_d = brake_time_q;
        // R17: wait for bootstrap UVLO
        end else if (uvlo_s2_q) begin
          state_d = MSS_SPEED_DETECT;
        end
      end
      MSS_SPEED_DETECT: begin
        // R18: results from ADC detection
        if (detect_done) begin
          // R06: stationary check
          if (bemf_level < stat_thr_q) begin
            state_d = brake_decide(brake_enable);
            tmr_d = brake_time_q;
          // R07: direction of spin
          end else if (!spin_reverse) begin
            // R08: resync decision
            if (resync_enable) begin
              // R09: closed loop or open loop
              state_d = (motor_speed > resync_thr_q) ? MSS_CLOSED_LOOP : MSS_OPEN_LOOP;
            end else begin
              state_d = coast_decide(coast_enable, brake_enable);
              tmr_d = coast_enable ? coast_time_q : brake_time_q;
            end
          // R10: reverse drive decision
          end else if (reverse_drive_enable) begin
            state_d = (motor_speed > handoff_thr_q) ? MSS_REV_CLOSED : MSS_REV_OPEN;
          end else begin
            state_d = coast_decide(coast_enable, brake_enable);
            tmr_d = coast_enable ? coast_time_q : brake_time_q;
          end
        end
      end
      MSS_COAST: begin
        // R21: coast expiry
        if (tmr_done) begin
          state_d = brake_decide(brake_enable);
          tmr_d = brake_time_q;
        end
      end
      // R22: brake expiry
      MSS_BRAKE: if (tmr_done) state_d = MSS_STARTUP;
      // R19: method done goes open loop
      MSS_STARTUP: if (method_done) state_d = MSS_OPEN_LOOP;
      MSS_OPEN_LOOP: if (motor_speed > handoff_thr_q) state_d = MSS_CLOSED_LOOP;
      // R11: reverse closed-loop decel
      MSS_REV_CLOSED: if (motor_speed <= handoff_thr_q) state_d = MSS_REV_OPEN;
      MSS_REV_OPEN: begin
        // R12: cross zero, then forward handoff
        if (zero_crossed && motor_speed > handoff_thr_q) state_d = MSS_CLOSED_LOOP;
      end
      MSS_CLOSED_LOOP: state_d = MSS_CLOSED_LOOP;
      default: state_d = MSS_POWER_ON;
    endcase
    // R03: power-on on wake; R04: restart on direction change
    if (wake_event || restart) state_d = MSS_POWER_ON;
  end

  // State, timer and event outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= MSS_POWER_ON;
      tmr_q <= '0;
      phase_q <= 2'd0;
      det_start_q <= 1'b0;
      seed_q <= 1'b0;
      method_q <= MSS_METHOD_ALIGN;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      phase_q <= phase_d;
      det_start_q <= (state_d == MSS_SPEED_DETECT) && (state_q != MSS_SPEED_DETECT);
      seed_q <= (state_q == MSS_SPEED_DETECT) && (state_d == MSS_CLOSED_LOOP);
      // R20: method code latched on start-up entry
      if (state_d == MSS_STARTUP && state_q != MSS_STARTUP) method_q <= startup_method_select;
    end
  end

  // PWM period counter for precharge pulses
  // Held at zero outside precharge so each precharge opens with a pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) pwm_q <= '0;
    else pwm_q <= (state_q != MSS_PRECHARGE || pwm_q >= pwm_period_q - TW'(1)) ? '0 : pwm_q + TW'(1);
  end

  // Gate drive: precharge, brake, coast, otherwise off (drive loops are outside)
  // Registered so no decode glitch reaches a gate pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gl_q <= 3'b000;
      gh_q <= 3'b000;
    end else begin
      gh_q <= 3'b000;
      gl_q <= 3'b000;
      // R01: 5% low-side pulse on current phase
      if (state_d == MSS_PRECHARGE && state_q == MSS_PRECHARGE && pwm_q < ls_on_time)
        gl_q <= 3'b001 << phase_q;
      // R16: all low sides on in brake
      if (state_d == MSS_BRAKE) gl_q <= 3'b111;
      // R14: coast keeps all six off (default above)
    end
  end

  assign gate_low = gl_q;
  assign gate_high = gh_q;
  assign detect_start = det_start_q;
  assign seed_closed_loop = seed_q;
  assign method_run = method_q;
  assign fsm_state = state_q;

  // Assertions
  brake_lows_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
    state_q == MSS_BRAKE |-> gl_q == 3'b111 && gh_q == 3'b000)
    else $error("brake gates wrong");
  coast_all_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    state_q == MSS_COAST |-> gl_q == 3'b000 && gh_q == 3'b000)
    else $error("coast gates not off");
  precharge_one_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R01
    state_q == MSS_PRECHARGE |-> gh_q == 3'b000 && $countones(gl_q) <= 1)
    else $error("precharge gate misuse");
  dir_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R04
    dir_change && !dir_restart_mode |=> state_q == MSS_POWER_ON)
    else $error("direction restart missed");
  wake_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R03
    wake_event |=> state_q == MSS_POWER_ON)
    else $error("wake restart missed");
  uvlo_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
    state_q == MSS_WAIT_UVLO && !uvlo_s2_q |=> state_q != MSS_SPEED_DETECT)
    else $error("detect before uvlo");
  skip_detect_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R05
    state_q == MSS_WAIT_UVLO && !speed_detect_enable && !wake_event && !restart
    |=> state_q inside {MSS_BRAKE, MSS_STARTUP})
    else $error("detect skip wrong");
  stationary_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R06
    state_q == MSS_SPEED_DETECT && detect_done && bemf_level < stat_thr_q && !wake_event
    && !restart |=> state_q inside {MSS_BRAKE, MSS_STARTUP})
    else $error("stationary path wrong");
  resync_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R09
    state_q == MSS_SPEED_DETECT && detect_done && bemf_level >= stat_thr_q && !spin_reverse
    && resync_enable && motor_speed > resync_thr_q && !wake_event && !restart
    |=> state_q == MSS_CLOSED_LOOP && seed_q)
    else $error("resync path wrong");
  method_open_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
    state_q == MSS_STARTUP && method_done && !wake_event && !restart |=> state_q == MSS_OPEN_LOOP)
    else $error("method exit wrong");

  // Entry into a state
  sequence detect_entry_s;
    state_q != MSS_SPEED_DETECT ##1 state_q == MSS_SPEED_DETECT;
  endsequence : detect_entry_s

  sequence coast_entry_s;
    state_q != MSS_COAST ##1 state_q == MSS_COAST;
  endsequence : coast_entry_s

  sequence brake_entry_s;
    state_q != MSS_BRAKE ##1 state_q == MSS_BRAKE;
  endsequence : brake_entry_s

  // Detection requested on entry
  detect_req_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R18
    detect_entry_s |-> det_start_q)
    else $error("detect request missing");

  // Timers start from the durations
  coast_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    coast_entry_s |-> tmr_q == coast_time_q)
    else $error("coast duration wrong");

  brake_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
    brake_entry_s |-> tmr_q == brake_time_q)
    else $error("brake duration wrong");

  // Expiry moves the flow on
  coast_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R21
    state_q == MSS_COAST && tmr_done && no_restart
    |=> state_q inside {MSS_BRAKE, MSS_STARTUP})
    else $error("coast exit wrong");

  brake_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R22
    state_q == MSS_BRAKE && tmr_done && no_restart |=> state_q == MSS_STARTUP)
    else $error("brake exit wrong");

  // Precharge walks the phases in order
  power_on_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R02
    state_q == MSS_POWER_ON && no_restart |=> state_q == MSS_PRECHARGE && phase_q == 2'd0)
    else $error("precharge start wrong");

  phase_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R02
    state_q == MSS_PRECHARGE && tmr_done && phase_q != 2'd2 && no_restart
    |=> state_q == MSS_PRECHARGE && phase_q == $past(phase_q) + 2'd1)
    else $error("phase order wrong");

  // Reverse drive holds until its exit
  rev_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
    state_q == MSS_REV_CLOSED && motor_speed > handoff_thr_q && no_restart
    |=> state_q == MSS_REV_CLOSED)
    else $error("reverse hold wrong");

  rev_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
    state_q == MSS_REV_OPEN && !zero_crossed && no_restart |=> state_q == MSS_REV_OPEN)
    else $error("reverse zero wait wrong");
endmodule : mss_start_sequencer

// ===== test/mss_bridge_model.sv
`timescale 1ns/1ps
module mss_bridge_model (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Sync reset
  input wire logic detect_start, // Detection request
  input wire mss_pkg::mss_state_t fsm_state, // Sequencer state
  input wire logic [15:0] cfg_bemf, // Back-EMF the motor shows
  input wire logic [15:0] cfg_speed, // Speed at detection
  input wire logic cfg_rev, // Motor turns against command
  output logic detect_done, // Result strobe
  output logic [15:0] bemf_level, // Back-EMF sample
  output logic [15:0] motor_speed, // Speed magnitude
  output logic spin_reverse, // Direction sample
  output logic method_done, // Start-up method over
  output logic zero_crossed // Reverse speed passed zero
);
  import mss_pkg::*;
  logic [2:0] dly_q;
  logic [1:0] mcnt_q;
  // Samples hold only in the strobe cycle, the inverse elsewhere
  assign bemf_level = detect_done ? cfg_bemf : ~cfg_bemf;
  assign spin_reverse = detect_done ? cfg_rev : ~cfg_rev;
  // sampled result after a delay; speed runs down, through zero, up
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dly_q <= 3'h0;
      detect_done <= 1'b0;
      motor_speed <= 16'h0000;
      zero_crossed <= 1'b0;
      method_done <= 1'b0;
      mcnt_q <= 2'h0;
    end else begin
      detect_done <= (dly_q == 3'h1);
      dly_q <= detect_start ? 3'h5 : ((dly_q != 3'h0) ? dly_q - 3'h1 : 3'h0);
      if (detect_start) begin
        motor_speed <= cfg_speed;
        zero_crossed <= 1'b0;
      end else if (fsm_state inside {MSS_REV_CLOSED, MSS_REV_OPEN}) begin
        if (!zero_crossed && motor_speed != 16'h0000) begin
          motor_speed <= motor_speed - 16'h0001;
        end else begin
          zero_crossed <= 1'b1;
          motor_speed <= motor_speed + 16'h0001;
        end
      end
      // method finishes a few cycles into start-up
      method_done <= (fsm_state == MSS_STARTUP) && (mcnt_q == 2'h2);
      mcnt_q <= (fsm_state == MSS_STARTUP) ? mcnt_q + 2'h1 : 2'h0;
    end
  end
endmodule : mss_bridge_model

// ===== test/mss_start_sequencer_bench.sv
`timescale 1ns/1ps
module mss_start_sequencer_bench;
  import mss_pkg::*;
  localparam int PWM_T = 40;
  localparam int BST_T = 120;
  localparam int HOLD_T = 4;
  localparam int THR = 16;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, wake_event = 1'b0, dir_change = 1'b0, uvlo_ok = 1'b1;
  logic [15:0] cfg_bemf = 16'h0000, cfg_speed = 16'h0000;
  logic cfg_rev = 1'b0;
  logic [15:0] reg_rdata, bemf_level, motor_speed;
  logic detect_done, spin_reverse, method_done, zero_crossed, detect_start, seed_closed_loop;
  logic [1:0] method_run, mrun;
  logic [2:0] gate_high, gate_low, seen;
  mss_state_t fsm_state, prev_state;
  mss_state_t obs[$];
  mss_state_t exq[$];
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int coast_n, brake_n, seeds, run_n, max_run, det_n;
  logic exp_seed;
  mss_start_sequencer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_event(wake_event), .dir_change(dir_change), .boot_uvlo_ok_pin(uvlo_ok),
    .detect_done(detect_done), .bemf_level(bemf_level), .motor_speed(motor_speed),
    .spin_reverse(spin_reverse), .method_done(method_done), .zero_crossed(zero_crossed),
    .detect_start(detect_start), .seed_closed_loop(seed_closed_loop), .method_run(method_run),
    .gate_high(gate_high), .gate_low(gate_low), .fsm_state(fsm_state));
  mss_bridge_model bridge_u (.ref_clk(ref_clk), .rst_n(rst_n), .detect_start(detect_start),
    .fsm_state(fsm_state), .cfg_bemf(cfg_bemf), .cfg_speed(cfg_speed), .cfg_rev(cfg_rev),
    .detect_done(detect_done), .bemf_level(bemf_level), .motor_speed(motor_speed),
    .spin_reverse(spin_reverse), .method_done(method_done), .zero_crossed(zero_crossed));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Trace state changes, gate levels and precharge pulse widths
  always @(negedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
    if (rst_n) begin
      if (fsm_state !== prev_state) obs.push_back(fsm_state);
      cmp("gate_high", 16'h0, {13'h0, gate_high});
      if (fsm_state == MSS_COAST) coast_n++;
      if (fsm_state == MSS_COAST) cmp("coast_gate", 16'h0, {13'h0, gate_low});
      if (fsm_state == MSS_BRAKE) brake_n++;
      if (fsm_state == MSS_BRAKE) cmp("brake_gate", 16'h7, {13'h0, gate_low});
      if (fsm_state == MSS_STARTUP) mrun = method_run;
      if (seed_closed_loop === 1'b1) seeds++;
      if (detect_start === 1'b1) det_n++;
      if (fsm_state == MSS_PRECHARGE) begin
        cmp("pre_phase", 16'h1, {15'h0, $onehot0(gate_low)});
        seen = seen | gate_low;
        run_n = (gate_low != 3'h0) ? run_n + 1 : 0;
        if (run_n > max_run) max_run = run_n;
      end
    end
    prev_state = fsm_state;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp(what, exp, reg_rdata);
  endtask : rd
  // Reference model of the decision flow
  function automatic void build(input logic [7:0] c, input int b, input int s, input bit r);
    exq = {MSS_POWER_ON, MSS_PRECHARGE, MSS_WAIT_UVLO};
    exp_seed = 1'b0;
    if (c[0]) exq.push_back(MSS_SPEED_DETECT);
    if (c[0] && b >= THR) begin
      if (!r && c[1]) begin
        exp_seed = (s > THR);
        exq.push_back(exp_seed ? MSS_CLOSED_LOOP : MSS_OPEN_LOOP);
        return;
      end
      if (r && c[2]) begin
        if (s > THR) exq.push_back(MSS_REV_CLOSED);
        exq.push_back(MSS_REV_OPEN);
        exq.push_back(MSS_CLOSED_LOOP);
        return;
      end
      if (c[3]) exq.push_back(MSS_COAST);
    end
    if (c[4]) exq.push_back(MSS_BRAKE);
    exq.push_back(MSS_STARTUP);
    exq.push_back(MSS_OPEN_LOOP);
  endfunction : build
  task automatic run(input logic [7:0] c, input int b, input int s, input bit r);
    wr(MSS_REG_CTRL, {8'h00, c});
    cfg_bemf <= b[15:0];
    cfg_speed <= s[15:0];
    cfg_rev <= r;
    @(posedge ref_clk);
    obs.delete();
    {coast_n, brake_n, seeds, run_n, max_run, det_n} = '0;
    seen = 3'h0;
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    repeat (400) @(posedge ref_clk);
    build(c, b, s, r);
    foreach (exq[i]) cmp("path", exq[i], (i < obs.size()) ? 16'(obs[i]) : 16'hffff);
    cmp("pre_seen", 16'h7, {13'h0, seen});
    cmp("pre_on", 16'(PWM_T * MSS_LS_ON_PCT / 100), 16'(max_run));
    cmp("seed", {15'h0, exp_seed}, 16'(seeds));
    cmp("detect_req", {15'h0, c[0]}, 16'(det_n));
    if (MSS_COAST inside {exq}) cmp("coast_n", 16'h1, 16'(coast_n inside {[4:6]}));
    if (MSS_BRAKE inside {exq}) cmp("brake_n", 16'h1, 16'(brake_n inside {[4:6]}));
    if (MSS_STARTUP inside {exq}) cmp("method", {14'h0, c[7:6]}, {14'h0, mrun});
  endtask : run
  initial begin
    void'($urandom(30));
    repeat (5) @(posedge ref_clk);
    #1 cmp("rst_state", 16'(MSS_POWER_ON), 16'(fsm_state));
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(MSS_REG_CTRL, {8'h00, MSS_CTRL_RST}, "ctrl_rst");
    wr(4'hf, 16'($urandom));
    rd(4'hf, 16'h0000, "unmapped");
    wr(MSS_REG_BST_TIME, 16'(BST_T));
    wr(MSS_REG_COAST_TIME, 16'(HOLD_T));
    wr(MSS_REG_BRAKE_TIME, 16'(HOLD_T));
    wr(MSS_REG_PWM_PERIOD, 16'(PWM_T));
    rd(MSS_REG_COAST_TIME, 16'(HOLD_T), "coast_time");
    // Detection must wait for the bootstrap supply
    wr(MSS_REG_CTRL, 16'h0001);
    uvlo_ok <= 1'b0;
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    repeat (300) @(posedge ref_clk);
    #1 cmp("uvlo_hold", 16'(MSS_WAIT_UVLO), 16'(fsm_state));
    rd(MSS_REG_STATUS, {8'h00, 1'b0, 2'd2, 1'b0, 4'(MSS_WAIT_UVLO)}, "status");
    @(posedge ref_clk);
    uvlo_ok <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 cmp("uvlo_go", 16'h1, 16'(fsm_state != MSS_WAIT_UVLO));
    for (int m = 0; m < 4; m++) run({m[1:0], 6'h10}, 0, 0, 1'b0);
    run(8'h00, 0, 0, 1'b0);
    run(8'h19, $urandom % THR, 40, 1'b0);
    run(8'h03, THR + $urandom % 100, THR + 1 + $urandom % 50, 1'b0);
    // Direction change ignored while restart mode is set
    wr(MSS_REG_CTRL, 16'h0023);
    obs.delete();
    dir_change <= 1'b1;
    @(posedge ref_clk);
    dir_change <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp("no_restart", 16'h0, 16'(obs.size()));
    // Direction change while in closed loop restarts the sequence
    wr(MSS_REG_CTRL, 16'h0003);
    obs.delete();
    dir_change <= 1'b1;
    @(posedge ref_clk);
    dir_change <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp("restart", 16'(MSS_POWER_ON), obs.size() ? 16'(obs[0]) : 16'hffff);
    run(8'h03, THR + $urandom % 100, $urandom % (THR + 1), 1'b0);
    run(8'h09, THR + $urandom % 100, 40, 1'b0);
    run(8'h05, THR + $urandom % 100, THR + 1 + $urandom % 50, 1'b1);
    run(8'h05, THR + $urandom % 100, $urandom % (THR + 1), 1'b1);
    run(8'h19, THR + $urandom % 100, 30, 1'b1);
    final_report();
  end
endmodule : mss_start_sequencer_bench
